// File: fault_limit_response_control.v
// Fault limit registers and response control of a point-of-load regulator
`timescale 1ns/1ps
`default_nettype none
`include "fault_limit_regs.vh"
module fault_limit_response_control #(
	parameter OC_RUN_CYC = `US_TO_CYC(`OC_RUN_UNIT_US),
	parameter OC_RETRY_CYC = `US_TO_CYC(`OC_RETRY_UNIT_US),
	parameter OT_RUN_CYC = `US_TO_CYC(`OT_RUN_UNIT_US),
	parameter OT_RETRY_CYC = `US_TO_CYC(`OT_RETRY_UNIT_US)
) (
	// Clock and reset
	input wire clk_i,
	input wire arst_n_i,
	// Command port from the PMBus interface logic
	input wire cmd_wr_i,
	input wire cmd_rd_i,
	input wire [7:0] cmd_code_i,
	input wire [15:0] cmd_wdata_i,
	output reg [15:0] cmd_rdata_o,
	output reg cmd_ack_o,
	// Comparator outputs from the analog sense path
	input wire oc_fault_i,
	input wire uc_fault_i,
	input wire ot_fault_i,
	// Host control
	input wire clear_faults_i,
	input wire out_enable_i,
	// Results
	output reg alert_out_n,
	output reg [2:0] fault_status_o,
	output reg out_enable_o,
	output reg [15:0] oc_limit_o,
	output reg [15:0] uc_limit_o,
	output reg [15:0] ot_limit_o
);
	reg [7:0] ot_action_r;
	reg [7:0] oc_action_r;
	reg [2:0] flt_s1_r;
	reg [2:0] flt_s2_r;
	reg [1:0] ctl_s1_r;
	reg [1:0] ctl_s2_r;
	reg [2:0] status_r;
	wire [2:0] set;
	wire [2:0] ok;
	wire clr = ctl_s2_r[0];
	wire en = ctl_s2_r[1];
	wire [7:0] act_sel [0:2];
	assign act_sel[0] = oc_action_r;
	assign act_sel[1] = oc_action_r;
	assign act_sel[2] = ot_action_r;

	// Fault and control pins come from outside the clock domain
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			flt_s1_r <= 3'h0;
			flt_s2_r <= 3'h0;
			ctl_s1_r <= 2'h0;
			ctl_s2_r <= 2'h0;
		end else begin
			flt_s1_r <= {ot_fault_i, uc_fault_i, oc_fault_i};
			flt_s2_r <= flt_s1_r;
			ctl_s1_r <= {out_enable_i, clear_faults_i};
			ctl_s2_r <= ctl_s1_r;
		end
	end

	// One sequencer per fault; current faults share a unit pair
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : resp
			fault_responder #(
				.RUN_UNIT_CYC(g == 2 ? OT_RUN_CYC : OC_RUN_CYC),
				.RETRY_UNIT_CYC(g == 2 ? OT_RETRY_CYC : OC_RETRY_CYC)
			) u_resp (
				.clk_i(clk_i),
				.arst_n_i(arst_n_i),
				.action_i(act_sel[g]),
				.fault_i(flt_s2_r[g]),
				.clear_i(clr),
				.out_enable_i(en),
				.fault_set_o(set[g]),
				.out_ok_o(ok[g])
			);
		end
	endgenerate

	// Register file; a new fault wins over a clear in the same cycle
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			oc_limit_o <= `LIMIT_RESET;
			uc_limit_o <= `LIMIT_RESET;
			ot_limit_o <= `LIMIT_RESET;
			ot_action_r <= `ACTION_RESET;
			oc_action_r <= `ACTION_RESET;
			cmd_rdata_o <= 16'h0000;
			cmd_ack_o <= 1'b0;
			status_r <= 3'h0;
			fault_status_o <= 3'h0;
			alert_out_n <= 1'b1;
			out_enable_o <= 1'b0;
		end else begin
			cmd_ack_o <= cmd_wr_i | cmd_rd_i;
			if (cmd_wr_i) begin
				case (cmd_code_i)
					`CMD_OC_PEAK_LIMIT: oc_limit_o <= cmd_wdata_i;
					`CMD_UC_LIMIT: uc_limit_o <= cmd_wdata_i;
					`CMD_OT_THRESHOLD: ot_limit_o <= cmd_wdata_i;
					`CMD_OT_ACTION: ot_action_r <= cmd_wdata_i[7:0];
					`CMD_OC_ACTION: oc_action_r <= cmd_wdata_i[7:0];
					default: ;
				endcase
			end
			if (cmd_rd_i) begin
				case (cmd_code_i)
					`CMD_OC_PEAK_LIMIT: cmd_rdata_o <= oc_limit_o;
					`CMD_UC_LIMIT: cmd_rdata_o <= uc_limit_o;
					`CMD_OT_THRESHOLD: cmd_rdata_o <= ot_limit_o;
					`CMD_OT_ACTION: cmd_rdata_o <= {8'h00, ot_action_r};
					`CMD_OC_ACTION: cmd_rdata_o <= {8'h00, oc_action_r};
					default: cmd_rdata_o <= 16'h0000;
				endcase
			end
			status_r <= (clr ? 3'h0 : status_r) | set;
			fault_status_o <= (clr ? 3'h0 : status_r) | set;
			alert_out_n <= ~|((clr ? 3'h0 : status_r) | set);
			out_enable_o <= en & (&ok);
		end
	end
endmodule
`default_nettype wire

// File: fault_limit_regs.vh
// Command codes, field positions and timing figures of the fault supervisor
`ifndef FAULT_LIMIT_REGS_VH
`define FAULT_LIMIT_REGS_VH
`define CMD_OC_PEAK_LIMIT 8'h4a
`define CMD_UC_LIMIT 8'h4b
`define CMD_OT_THRESHOLD 8'h4f
`define CMD_OT_ACTION 8'h50
`define CMD_OC_ACTION 8'h51
`define ACT_HI 7
`define ACT_LO 6
`define RETRY_HI 5
`define RETRY_LO 3
`define DELAY_HI 2
`define DELAY_LO 0
`define ACT_IGNORE 2'h0
`define ACT_RUN_DELAY 2'h1
`define ACT_DISABLE_RETRY 2'h2
`define ACT_UNTIL_CLEAR 2'h3
`define RETRY_FOREVER 3'h7
`define LIMIT_RESET 16'h0000
`define ACTION_RESET 8'h00
// Unit times in microseconds and the clock rate in kHz
`define CLK_KHZ 10000
`define OC_RUN_UNIT_US 10000
`define OC_RETRY_UNIT_US 8200
`define OT_RUN_UNIT_US 80000
`define OT_RETRY_UNIT_US 32000
`define US_TO_CYC(us) ((us) * `CLK_KHZ / 1000)
`endif

// File: unit_timer.v
// Delay timer counting a number of fixed-length time units
`timescale 1ns/1ps
`default_nettype none
module unit_timer #(
	parameter UNIT_CYC = 100000
) (
	// Clock and reset
	input wire clk_i,
	input wire arst_n_i,
	// Control
	input wire start_i,
	input wire [2:0] units_i,
	output reg done_o
);
	reg [19:0] cyc_r;
	reg [2:0] left_r;
	reg busy_r;
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cyc_r <= 20'h00000;
			left_r <= 3'h0;
			busy_r <= 1'b0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (start_i) begin
				// Zero units still gives a one-cycle wait
				cyc_r <= 20'h00000;
				left_r <= units_i;
				busy_r <= 1'b1;
			end else if (busy_r) begin
				if (left_r == 3'h0) begin
					busy_r <= 1'b0;
					done_o <= 1'b1;
				end else if (cyc_r == UNIT_CYC[19:0] - 20'h00001) begin
					cyc_r <= 20'h00000;
					left_r <= left_r - 3'h1;
				end else begin
					cyc_r <= cyc_r + 20'h00001;
				end
			end
		end
	end
endmodule
`default_nettype wire

// File: fault_responder.v
// Response sequencer for one fault type: action, retries and delays
`timescale 1ns/1ps
`default_nettype none
`include "fault_limit_regs.vh"
module fault_responder #(
	parameter RUN_UNIT_CYC = 100000,
	parameter RETRY_UNIT_CYC = 82000
) (
	// Clock and reset
	input wire clk_i,
	input wire arst_n_i,
	// Setting and fault
	input wire [7:0] action_i,
	input wire fault_i,
	input wire clear_i,
	input wire out_enable_i,
	// Results
	output reg fault_set_o,
	output reg out_ok_o
);
	localparam S_IDLE = 3'd0;
	localparam S_RUN = 3'd1;
	localparam S_WAIT = 3'd2;
	localparam S_TRY = 3'd3;
	localparam S_LATCH = 3'd4;
	localparam S_HOLD = 3'd5;
	reg [2:0] st_r;
	reg [2:0] st_nxt;
	reg [2:0] tries_r;
	reg fault_d_r;
	reg t_start_r;
	reg r_start_r;
	wire run_done;
	wire retry_done;
	wire [1:0] act = action_i[`ACT_HI:`ACT_LO];
	wire [2:0] retry = action_i[`RETRY_HI:`RETRY_LO];
	wire [2:0] dly = action_i[`DELAY_HI:`DELAY_LO];
	wire rise = fault_i & ~fault_d_r;
	wire more = (retry == `RETRY_FOREVER) || (tries_r < retry);
	unit_timer #(.UNIT_CYC(RUN_UNIT_CYC)) run_tmr (
		.clk_i(clk_i), .arst_n_i(arst_n_i), .start_i(t_start_r),
		.units_i(dly), .done_o(run_done));
	unit_timer #(.UNIT_CYC(RETRY_UNIT_CYC)) retry_tmr (
		.clk_i(clk_i), .arst_n_i(arst_n_i), .start_i(r_start_r),
		.units_i(dly), .done_o(retry_done));
	always @* begin
		st_nxt = st_r;
		case (st_r)
			S_IDLE: begin
				if (rise) begin
					if (act == `ACT_RUN_DELAY)
						st_nxt = S_RUN;
					else if (act == `ACT_DISABLE_RETRY)
						st_nxt = more ? S_WAIT : S_LATCH;
					else if (act == `ACT_UNTIL_CLEAR)
						st_nxt = S_HOLD;
				end
			end
			S_RUN: if (run_done) st_nxt = !fault_i ? S_IDLE : (more ? S_WAIT : S_LATCH);
			S_WAIT: if (retry_done) st_nxt = S_TRY;
			S_TRY: st_nxt = !fault_i ? S_IDLE : (more ? S_WAIT : S_LATCH);
			S_LATCH: if (clear_i) st_nxt = S_IDLE;
			S_HOLD: if (!fault_i) st_nxt = S_IDLE;
			default: st_nxt = S_IDLE;
		endcase
		// Endless retry stops when the output is switched off by the host
		if (!out_enable_i && st_r != S_LATCH) st_nxt = S_IDLE;
	end
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_r <= S_IDLE;
			tries_r <= 3'h0;
			fault_d_r <= 1'b0;
			t_start_r <= 1'b0;
			r_start_r <= 1'b0;
			fault_set_o <= 1'b0;
			out_ok_o <= 1'b1;
		end else begin
			st_r <= st_nxt;
			fault_d_r <= fault_i;
			fault_set_o <= rise;
			t_start_r <= (st_nxt == S_RUN) && (st_r != S_RUN);
			r_start_r <= (st_nxt == S_WAIT) && (st_r != S_WAIT);
			if (st_nxt == S_IDLE || clear_i)
				tries_r <= 3'h0;
			else if (st_r == S_WAIT && st_nxt == S_TRY && tries_r != 3'h7)
				tries_r <= tries_r + 3'h1;
			// Action 00 never leaves idle, so the output stays up
			out_ok_o <= (st_nxt == S_IDLE) || (st_nxt == S_RUN) ||
				(st_nxt == S_TRY);
		end
	end
endmodule
`default_nettype wire

// File: fault_limit_sva.sv
// Port assertions for the fault supervisor
`timescale 1ns/1ps
`default_nettype none
`include "fault_limit_regs.vh"
module fault_limit_sva (
	// Ports watched
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic cmd_wr_i,
	input wire logic cmd_rd_i,
	input wire logic [7:0] cmd_code_i,
	input wire logic [15:0] cmd_wdata_i,
	input wire logic [15:0] cmd_rdata_o,
	input wire logic cmd_ack_o,
	input wire logic ot_fault_i,
	input wire logic clear_faults_i,
	input wire logic out_enable_i,
	input wire logic alert_out_n,
	input wire logic [2:0] fault_status_o,
	input wire logic out_enable_o,
	input wire logic [15:0] uc_limit_o,
	input wire logic [15:0] ot_limit_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	sequence s_req;
		cmd_wr_i || cmd_rd_i;
	endsequence
	// Four low samples outlast the two-stage synchroniser
	sequence s_host_off;
		!out_enable_i [*4];
	endsequence
	chk_ack_after_req: assert property (s_req |=> cmd_ack_o)
		else $error("ack missing");
	chk_ack_cause: assert property (cmd_ack_o |-> $past(cmd_wr_i) || $past(cmd_rd_i))
		else $error("stray ack");
	chk_uc_read: assert property (cmd_rd_i && !cmd_wr_i && cmd_code_i == `CMD_UC_LIMIT
		|=> cmd_rdata_o == $past(uc_limit_o)) else $error("bad read");
	chk_ot_write: assert property (cmd_wr_i && cmd_code_i == `CMD_OT_THRESHOLD
		|=> ot_limit_o == $past(cmd_wdata_i)) else $error("bad write");
	chk_action_byte: assert property (cmd_rd_i && cmd_code_i == `CMD_OT_ACTION
		|=> cmd_rdata_o[15:8] == 8'h00) else $error("byte high");
	chk_alert_status: assert property (alert_out_n == (fault_status_o == 3'h0))
		else $error("alert mismatch");
	chk_fault_alert: assert property ($rose(ot_fault_i) |-> ##[1:5]
		(!alert_out_n && fault_status_o[2])) else $error("late alert");
	chk_status_hold: assert property (!clear_faults_i [*4] ##0 fault_status_o[2]
		|=> fault_status_o[2]) else $error("status lost");
	chk_host_off: assert property (s_host_off |=> !out_enable_o)
		else $error("output stays on");
endmodule
bind fault_limit_response_control fault_limit_sva u_chk (.*);
`default_nettype wire

// File: host_model.sv
// Host controller model driving the command port
`timescale 1ns/1ps
`default_nettype none
module host_model (
	// Clock
	input wire logic clk_i,
	// Command port
	output logic wr_o = 1'b0,
	output logic rd_o = 1'b0,
	output logic [7:0] code_o = 8'h00,
	output logic [15:0] wdata_o = 16'h0000,
	input wire logic ack_i,
	input wire logic [15:0] rdata_i
);
	// Requests that never saw an ack; the bench adds them to its mismatches
	int misses = 0;
	// Request held until ack is sampled; a repeated take is harmless here
	task automatic acc(input logic w, input logic [7:0] c, input logic [15:0] d,
		output logic [15:0] q);
		int n;
		n = 0;
		wr_o <= w;
		rd_o <= !w;
		code_o <= c;
		wdata_o <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_i !== 1'b1 && n < 20);
		if (ack_i !== 1'b1) begin
			misses++;
		end
		q = rdata_i;
		wr_o <= 1'b0;
		rd_o <= 1'b0;
		@(posedge clk_i);
	endtask
endmodule
`default_nettype wire

// File: fault_limit_response_control_tb.sv
// Testbench of the fault supervisor
`timescale 1ns/1ps
`default_nettype none
`include "fault_limit_regs.vh"
module fault_limit_response_control_tb;
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic cmd_wr_i, cmd_rd_i, cmd_ack_o, alert_out_n, out_enable_o;
	logic [7:0] cmd_code_i;
	logic [15:0] cmd_wdata_i, cmd_rdata_o, oc_limit_o, uc_limit_o, ot_limit_o, q;
	logic [2:0] fault_status_o;
	logic oc_fault_i = 0, uc_fault_i = 0, ot_fault_i = 0, clear_faults_i = 0, out_enable_i = 1;
	int fail_count = 0, cmp_count = 0, cycles = 0, rises = 0, base = 0;
	logic oe_d = 1'b0;
	logic [7:0] row_code [6] = '{8'h4a, 8'h4b, 8'h4f, 8'h50, 8'h51, 8'h33};
	logic [15:0] row_data [6] = '{16'hffff, 16'h1234, 16'habcd, 16'h12c5, 16'h0041, 16'h5555};
	logic [15:0] row_exp [6] = '{16'hffff, 16'h1234, 16'habcd, 16'h00c5, 16'h0041, 16'h0000};
	// Short units keep every retry sequence within a few hundred cycles
	fault_limit_response_control #(.OC_RUN_CYC(10), .OC_RETRY_CYC(10), .OT_RUN_CYC(10),
		.OT_RETRY_CYC(10)) uut (.*);
	host_model h (.clk_i(clk_i), .wr_o(cmd_wr_i), .rd_o(cmd_rd_i), .code_o(cmd_code_i),
		.wdata_o(cmd_wdata_i), .ack_i(cmd_ack_o), .rdata_i(cmd_rdata_o));
	always #50 clk_i = ~clk_i;
	task automatic finish_test();
		fail_count += h.misses;
		$display("checks %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		oe_d <= out_enable_o;
		if (out_enable_o === 1'b1 && oe_d === 1'b0) begin
			rises <= rises + 1;
		end
		if (cycles == 20000) begin
			fail_count++;
			finish_test();
		end
	end
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic clear_all();
		{oc_fault_i, uc_fault_i, ot_fault_i} <= 3'h0;
		clear_faults_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		clear_faults_i <= 1'b0;
		repeat (10) @(posedge clk_i);
	endtask
	task automatic ep(input logic [7:0] c, input logic [7:0] a, input logic [2:0] f);
		h.acc(1'b1, c, {8'h00, a}, q);
		{ot_fault_i, uc_fault_i, oc_fault_i} <= f;
		repeat (12) @(posedge clk_i);
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		check({alert_out_n, fault_status_o, out_enable_o}, 5'b10000);
		arst_n_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		for (int i = 0; i < 6; i++) begin
			h.acc(1'b1, row_code[i], row_data[i], q);
			h.acc(1'b0, row_code[i], 16'h0000, q);
			check(q, row_exp[i]);
		end
		for (int r = 0; r < 7; r++) begin
			base = rises;
			h.acc(1'b1, `CMD_OT_ACTION, {8'h00, 2'b10, r[2:0], 3'h1}, q);
			ot_fault_i <= 1'b1;
			repeat (200) @(posedge clk_i);
			check(16'(rises - base), 16'(r));
			check({alert_out_n, fault_status_o, out_enable_o}, 5'b01000);
			clear_all();
		end
		ep(`CMD_OT_ACTION, 8'h00, 3'b100);
		check({alert_out_n, fault_status_o, out_enable_o}, 5'b01001);
		clear_all();
		ep(`CMD_OT_ACTION, 8'h42, 3'b100);
		check(out_enable_o, 1'b1);
		repeat (40) @(posedge clk_i);
		check(out_enable_o, 1'b0);
		clear_all();
		ep(`CMD_OT_ACTION, 8'hc0, 3'b100);
		check(out_enable_o, 1'b0);
		ot_fault_i <= 1'b0;
		repeat (12) @(posedge clk_i);
		check(out_enable_o, 1'b1);
		clear_all();
		ep(`CMD_OC_ACTION, 8'h80, 3'b001);
		check({fault_status_o, out_enable_o}, 4'b0010);
		clear_all();
		ep(`CMD_OC_ACTION, 8'h80, 3'b010);
		check({fault_status_o, out_enable_o}, 4'b0100);
		clear_all();
		base = rises;
		ep(`CMD_OT_ACTION, 8'hb9, 3'b100);
		repeat (120) @(posedge clk_i);
		check(16'(rises - base >= 7), 16'h0001);
		out_enable_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		base = rises;
		repeat (40) @(posedge clk_i);
		check(16'(rises - base), 16'h0000);
		check(out_enable_o, 1'b0);
		check(oc_limit_o, 16'hffff);
		check(uc_limit_o, 16'h1234);
		check(ot_limit_o, 16'habcd);
		// Reset in mid-run with the fault pin still high
		arst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		check({alert_out_n, fault_status_o, out_enable_o}, 5'b10000);
		check(ot_limit_o, 16'h0000);
		check(cmd_rdata_o, 16'h0000);
		arst_n_i <= 1'b1;
		out_enable_i <= 1'b1;
		repeat (12) @(posedge clk_i);
		check({alert_out_n, fault_status_o, out_enable_o}, 5'b01001);
		finish_test();
	end
endmodule
`default_nettype wire
